// ### inc/ubn_defines.svh
`ifndef UBN_DEFINES_SVH
`define UBN_DEFINES_SVH

// Register indices; byte address is four times the index
`define UBN_IDX_CTRL3        8'h46
`define UBN_IDX_DATA         8'h47
`define UBN_IDX_CONFIG       8'h48
`define UBN_IDX_STATUS       8'h49

// Control three field positions
`define UBN_C3_RX_NINTH      7
`define UBN_C3_TX_NINTH      6
`define UBN_C3_TX_DIR        5
`define UBN_C3_TX_INV        4
`define UBN_C3_OR_IE         3
`define UBN_C3_NOISE_IE      2
`define UBN_C3_FRAMING_IE    1
`define UBN_C3_PARITY_IE     0
`define UBN_C3_RW_MASK       8'h7F

// Config field positions
`define UBN_CF_RX_INV        0
`define UBN_CF_LONG_BRK      1
`define UBN_CF_NINE_BIT      2
`define UBN_CF_LOOPBACK      3
`define UBN_CF_RX_SOURCE     4
`define UBN_CF_RW_MASK       8'h1F

// Status field positions, write one to clear
`define UBN_ST_PARITY        0
`define UBN_ST_FRAMING       1
`define UBN_ST_NOISE         2
`define UBN_ST_OVERRUN       3
`define UBN_ST_RX_FULL       4
`define UBN_ST_BRK           5

// Reset values
`define UBN_RST_CTRL3        8'h00
`define UBN_RST_CONFIG       8'h00
`define UBN_RST_STATUS       8'h00
`define UBN_RST_DATA         8'h00

// Break thresholds in bit times
`define UBN_BRK_NORMAL       10
`define UBN_BRK_LONG         11

`endif

// ### inc/ubn_pkg.sv
`default_nettype none
package ubn_pkg;
  typedef logic [7:0] ubn_byte_type;
  typedef logic [8:0] ubn_word9_type;
  typedef enum logic [1:0] {
    UBN_APB_IDLE   = 2'b00,
    UBN_APB_ACCESS = 2'b01,
    UBN_APB_DONE   = 2'b11
  } ubn_apb_state_type;
endpackage : ubn_pkg
`default_nettype wire

// ### core/ubn_break_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubn_defines.svh"

module ubn_break_counter #(
  parameter int CNT_W = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic bit_tick,
  input  wire logic rx_level,
  input  wire logic long_mode,
  output logic      break_pulse
);

  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] low_cnt_next;
  logic [CNT_W-1:0] threshold;
  logic             hit;
  logic             done_reg;

  // Threshold 10 bit times, 11 with long detection
  assign threshold    = long_mode ? CNT_W'(`UBN_BRK_LONG) : CNT_W'(`UBN_BRK_NORMAL);
  assign low_cnt_next = (low_cnt_reg == threshold) ? low_cnt_reg : low_cnt_reg + CNT_W'(1);
  assign hit          = bit_tick && !rx_level && !done_reg && (low_cnt_next == threshold);

  // Count consecutive low bit samples, restart on high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= '0;
      done_reg    <= 1'b0;
      break_pulse <= 1'b0;
    end else if (ce) begin
      break_pulse <= hit;
      if (bit_tick && rx_level) begin
        low_cnt_reg <= '0;
        done_reg    <= 1'b0;
      end else if (bit_tick) begin
        low_cnt_reg <= low_cnt_next;
        done_reg    <= done_reg | hit;
      end
    end
  end

endmodule // ubn_break_counter
`default_nettype wire

// ### core/ubn_top.sv
// Summary of operation
// - Receive inversion flips the serial input before all receive processing.
// - Long break detection raises the break threshold from 10 to 11 bits.
// - Long break detection stops the framing error flag from setting.
// - Nine-bit mode stores received ninth bit in control bit 7 with data.
// - Nine-bit mode: data write sends control bit 6 plus data to shifter.
// - Single-wire mode: control bit 5 sets transmit pin as input or output.
// - Control bit 4 inverts the serial transmit output polarity.
// - Control bit 3 gates the overrun flag onto the interrupt request.
// - Control bit 2 gates the noise flag onto the interrupt request.
// - Control bit 1 gates the framing error flag onto the interrupt request.
// - Control bit 0 gates the parity error flag onto the interrupt request.
// - Long break detection stops the receive-data-full flag from setting.
`timescale 1ns/1ps
`default_nettype none
`include "ubn_defines.svh"

module ubn_top #(
  parameter int CNT_W = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_pin,
  output logic             rx_line,
  input  wire logic        bit_tick,
  input  wire logic        rx_frame_done,
  input  wire logic [8:0]  rx_frame_word,
  input  wire logic        rx_framing_err,
  input  wire logic        rx_noise_err,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_overrun_err,
  input  wire logic        tx_serial,
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  output logic             tx_load,
  output logic      [8:0]  tx_word,
  output logic             nine_bit_mode,
  output logic             break_detect,
  output logic             serial_irq
);

  ubn_pkg::ubn_apb_state_type apb_state_reg;
  ubn_pkg::ubn_apb_state_type apb_state_next;
  ubn_pkg::ubn_byte_type      ctrl3_reg;
  ubn_pkg::ubn_byte_type      config_reg;
  ubn_pkg::ubn_byte_type      status_reg;
  ubn_pkg::ubn_byte_type      status_next;
  ubn_pkg::ubn_byte_type      rx_data_reg;
  ubn_pkg::ubn_byte_type      tx_data_reg;
  ubn_pkg::ubn_byte_type      rd_mux;
  ubn_pkg::ubn_byte_type      set_bits;
  ubn_pkg::ubn_byte_type      clr_bits;
  ubn_pkg::ubn_byte_type      ctrl3_view;
  logic                       tx_ninth_reg;
  logic                       rx_ninth_reg;
  logic                       tx_load_reg;
  logic                       brk_pulse;

  // Address decode; byte address is four times the index
  wire        word_ok   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire [7:0]  word_idx  = paddr[9:2];
  wire        hit_ctrl3 = word_ok && (word_idx == `UBN_IDX_CTRL3);
  wire        hit_data  = word_ok && (word_idx == `UBN_IDX_DATA);
  wire        hit_cfg   = word_ok && (word_idx == `UBN_IDX_CONFIG);
  wire        hit_stat  = word_ok && (word_idx == `UBN_IDX_STATUS);
  wire        mapped    = hit_ctrl3 | hit_data | hit_cfg | hit_stat;
  wire        acc_end   = (apb_state_reg == ubn_pkg::UBN_APB_ACCESS);
  wire        wr_stb    = acc_end && pwrite && mapped;
  wire        rd_stb    = acc_end && !pwrite && mapped;

  // Config bit views
  wire        rx_inv    = config_reg[`UBN_CF_RX_INV];
  wire        long_brk  = config_reg[`UBN_CF_LONG_BRK];
  wire        nine_bit  = config_reg[`UBN_CF_NINE_BIT];
  wire        single_wr = config_reg[`UBN_CF_LOOPBACK] && config_reg[`UBN_CF_RX_SOURCE];

  // Control three with read-only ninth receive bit on top
  assign ctrl3_view = {rx_ninth_reg, ctrl3_reg[6:0]};

  // Read data selection
  assign rd_mux = hit_ctrl3 ? ctrl3_view  :
                  hit_data  ? rx_data_reg :
                  hit_cfg   ? config_reg  :
                  hit_stat  ? status_reg  : 8'h00;

  // APB sequencing: two wait cycles, then ready
  always_comb begin
    apb_state_next = apb_state_reg;
    unique case (apb_state_reg)
      ubn_pkg::UBN_APB_IDLE:   if (psel && penable) apb_state_next = ubn_pkg::UBN_APB_ACCESS;
      ubn_pkg::UBN_APB_ACCESS: apb_state_next = ubn_pkg::UBN_APB_DONE;
      ubn_pkg::UBN_APB_DONE:   apb_state_next = ubn_pkg::UBN_APB_IDLE;
      default:                 apb_state_next = ubn_pkg::UBN_APB_IDLE;
    endcase
  end

  // Hardware flag sets; framing and full masked while long break detection is on
  always_comb begin
    set_bits = 8'h00;
    set_bits[`UBN_ST_PARITY]  = rx_frame_done && rx_parity_err;
    set_bits[`UBN_ST_FRAMING] = rx_frame_done && rx_framing_err && !long_brk;
    set_bits[`UBN_ST_NOISE]   = rx_frame_done && rx_noise_err;
    set_bits[`UBN_ST_OVERRUN] = rx_overrun_err;
    set_bits[`UBN_ST_RX_FULL] = rx_frame_done && !long_brk;
    set_bits[`UBN_ST_BRK]  = brk_pulse;
  end

  // Write-one clears and data read clears full flag; set wins
  always_comb begin
    clr_bits = 8'h00;
    if (wr_stb && hit_stat) begin
      clr_bits = pwdata[7:0];
    end
    if (rd_stb && hit_data) begin
      clr_bits[`UBN_ST_RX_FULL] = 1'b1;
    end
    status_next = (status_reg & ~clr_bits) | set_bits;
  end

  // Bus state and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= ubn_pkg::UBN_APB_IDLE;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h0000_0000;
    end else if (ce) begin
      apb_state_reg <= apb_state_next;
      pready        <= acc_end;
      pslverr       <= acc_end && !mapped;
      prdata        <= acc_end ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Software-written control and config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_reg  <= `UBN_RST_CTRL3;
      config_reg <= `UBN_RST_CONFIG;
    end else if (ce) begin
      if (wr_stb && hit_ctrl3) begin
        ctrl3_reg <= pwdata[7:0] & `UBN_C3_RW_MASK;
      end
      if (wr_stb && hit_cfg) begin
        config_reg <= pwdata[7:0] & `UBN_CF_RW_MASK;
      end
    end
  end

  // Transmit buffer: ninth bit joins data on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_reg  <= `UBN_RST_DATA;
      tx_ninth_reg <= 1'b0;
      tx_load_reg  <= 1'b0;
    end else if (ce) begin
      tx_load_reg <= wr_stb && hit_data;
      if (wr_stb && hit_data) begin
        tx_data_reg  <= pwdata[7:0];
        tx_ninth_reg <= nine_bit && ctrl3_reg[`UBN_C3_TX_NINTH];
      end
    end
  end

  // Receive buffer, ninth bit updated together with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg  <= `UBN_RST_DATA;
      rx_ninth_reg <= 1'b0;
      status_reg   <= `UBN_RST_STATUS;
    end else if (ce) begin
      status_reg <= status_next;
      if (set_bits[`UBN_ST_RX_FULL]) begin
        rx_data_reg  <= rx_frame_word[7:0];
        rx_ninth_reg <= nine_bit && rx_frame_word[8];
      end
    end
  end

  // Pin side: inversion, direction, interrupt combine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line    <= 1'b1;
      tx_pin_out <= 1'b1;
      tx_pin_oe  <= 1'b0;
      serial_irq <= 1'b0;
    end else if (ce) begin
      rx_line    <= rx_pin ^ rx_inv;
      tx_pin_out <= tx_serial ^ ctrl3_reg[`UBN_C3_TX_INV];
      tx_pin_oe  <= !single_wr || ctrl3_reg[`UBN_C3_TX_DIR];
      serial_irq <= (status_next[`UBN_ST_OVERRUN] && ctrl3_reg[`UBN_C3_OR_IE])
                 || (status_next[`UBN_ST_NOISE]   && ctrl3_reg[`UBN_C3_NOISE_IE])
                 || (status_next[`UBN_ST_FRAMING] && ctrl3_reg[`UBN_C3_FRAMING_IE])
                 || (status_next[`UBN_ST_PARITY]  && ctrl3_reg[`UBN_C3_PARITY_IE]);
    end
  end

  // Registered copies toward the frame engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load       <= 1'b0;
      tx_word       <= 9'h000;
      nine_bit_mode <= 1'b0;
      break_detect  <= 1'b0;
    end else if (ce) begin
      tx_load       <= tx_load_reg;
      tx_word       <= {tx_ninth_reg, tx_data_reg};
      nine_bit_mode <= nine_bit;
      break_detect  <= brk_pulse;
    end
  end

  // Break detector on the already inverted line
  ubn_break_counter #(
    .CNT_W (CNT_W)
  ) u_break (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .bit_tick    (bit_tick),
    .rx_level    (rx_line),
    .long_mode   (long_brk),
    .break_pulse (brk_pulse)
  );

endmodule // ubn_top
`default_nettype wire

// ### tb/ubn_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ubn_peer (
  input  wire logic       pclk,
  output logic            rx_pin,
  output logic            bit_tick,
  output logic            rx_frame_done,
  output logic [8:0]      rx_frame_word,
  output logic            rx_framing_err,
  output logic            rx_noise_err,
  output logic            rx_parity_err,
  output logic            rx_overrun_err
);
  // Idle line high, frame results junk until a frame is flagged
  initial begin
    rx_pin = 1'b1;
    bit_tick = 1'b0;
    rx_frame_done = 1'b0;
    rx_frame_word = 9'h1FF;
    {rx_noise_err, rx_framing_err, rx_parity_err} = 3'h7;
    rx_overrun_err = 1'b0;
  end
  // One frame; e is overrun, noise, framing, parity
  task automatic frame(input logic [8:0] w, input logic [3:0] e);
    @(posedge pclk);
    rx_frame_done <= 1'b1;
    rx_frame_word <= w;
    {rx_overrun_err, rx_noise_err, rx_framing_err, rx_parity_err} <= e;
    @(posedge pclk);
    rx_frame_done <= 1'b0;
    rx_frame_word <= ~w;
    {rx_overrun_err, rx_noise_err, rx_framing_err, rx_parity_err} <= {1'b0, ~e[2:0]};
  endtask
  // Hold a line level over n bit-time sampling pulses
  task automatic line(input int n, input logic lvl);
    @(posedge pclk);
    rx_pin <= lvl;
    repeat (n) begin
      repeat (2) @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
    end
  endtask
endmodule // ubn_peer
`default_nettype wire

// ### tb/ubn_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubn_defines.svh"
module ubn_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        rx_pin,
  input wire logic        rx_line,
  input wire logic        bit_tick,
  input wire logic        rx_frame_done,
  input wire logic        rx_framing_err,
  input wire logic        tx_serial,
  input wire logic        tx_pin_out,
  input wire logic        tx_pin_oe,
  input wire logic        tx_load,
  input wire logic        nine_bit_mode,
  input wire logic        break_detect,
  input wire logic        serial_irq,
  input wire logic [8:0]  tx_word
);
  logic [7:0] c3_s, cf_s, dat_s;
  logic [4:0] low_n;
  wire        wr_ok = psel && penable && pready && pwrite;
  // Shadow copies of control, config and last transmit data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c3_s <= 8'h00;
      cf_s <= 8'h00;
      dat_s <= 8'h00;
    end else begin
      if (wr_ok && paddr == {2'b00, `UBN_IDX_CTRL3, 2'b00}) c3_s <= pwdata[7:0] & 8'h7F;
      if (wr_ok && paddr == {2'b00, `UBN_IDX_CONFIG, 2'b00}) cf_s <= pwdata[7:0];
      if (psel && penable && pwrite && paddr == {2'b00, `UBN_IDX_DATA, 2'b00}) dat_s <= pwdata[7:0];
    end
  end
  // Consecutive low line samples at bit ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_n <= 5'd0;
    else if (bit_tick) low_n <= rx_line ? 5'd0 : low_n + {4'd0, low_n != 5'd31};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_frame_err;
    rx_frame_done && rx_framing_err && c3_s[1] && !cf_s[1] && !psel;
  endsequence
  a_rx_polarity: assert property (presetn && !psel |=>
    rx_line == ($past(rx_pin) ^ cf_s[0])) else $error("rx polarity wrong");
  a_break_thresh: assert property (break_detect |->
    low_n >= 5'd10 + {4'd0, cf_s[1]}) else $error("break below threshold");
  a_tx_word: assert property (tx_load |->
    tx_word == {cf_s[2] & c3_s[6], dat_s}) else $error("tx word wrong");
  a_pin_dir: assert property (presetn && !psel |=>
    tx_pin_oe == (cf_s[3] && cf_s[4] ? c3_s[5] : 1'b1)) else $error("pin direction wrong");
  a_tx_polarity: assert property (presetn && !psel |=>
    tx_pin_out == ($past(tx_serial) ^ c3_s[4])) else $error("tx polarity wrong");
  a_frame_irq: assert property (s_frame_err |-> ##[1:2] serial_irq)
    else $error("framing irq missing");
  a_irq_masked: assert property (!psel && c3_s[3:0] == 4'h0 |=> !serial_irq)
    else $error("irq while masked");
  a_nine_mode: assert property (!psel |=> nine_bit_mode == cf_s[2])
    else $error("nine bit mode wrong");
endmodule // ubn_top_chk
`default_nettype wire

// ### tb/ubn_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubn_defines.svh"
module ubn_top_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tx_serial = 1'b1, er, pready, pslverr, rx_pin, rx_line, bit_tick;
  logic        rx_frame_done, rx_framing_err, rx_noise_err, rx_parity_err, rx_overrun_err;
  logic        tx_pin_out, tx_pin_oe, tx_load, nine_bit_mode, break_detect, serial_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0]  tx_word, rx_frame_word, last_word = 9'h000, n_breaks = 9'h000;
  int          n_errors = 0, comparisons = 0;
  ubn_top ubn_top_i (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_pin, .rx_line, .bit_tick, .rx_frame_done, .rx_frame_word,
    .rx_framing_err, .rx_noise_err, .rx_parity_err, .rx_overrun_err, .tx_serial, .tx_pin_out,
    .tx_pin_oe, .tx_load, .tx_word, .nine_bit_mode, .break_detect, .serial_irq);
  ubn_peer ubn_peer_i (.pclk, .rx_pin, .bit_tick, .rx_frame_done, .rx_frame_word,
    .rx_framing_err, .rx_noise_err, .rx_parity_err, .rx_overrun_err);
  // Clock, toggling shifter output, capture of loaded words and break pulses
  always #50 pclk = ~pclk;
  always @(posedge pclk) tx_serial <= ~tx_serial;
  always @(posedge pclk) if (tx_load) last_word <= tx_word;
  always @(posedge pclk) if (break_detect) n_breaks <= n_breaks + 9'h001;
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, result left in rd and er
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 9'h001, 9'(pready));
      give_verdict();
    end
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `UBN_IDX_CTRL3, 0);
    chk("ctrl3 reset", 9'h000, rd[8:0]);
    apb(1, `UBN_IDX_CTRL3, 32'hFF);
    apb(0, `UBN_IDX_CTRL3, 0);
    chk("ctrl3 ro bit", 9'h07F, rd[8:0]);
    apb(0, 8'h4A, 0);
    chk("unmapped", 9'h001, 9'(er));
    $display("registers done");
    apb(1, `UBN_IDX_CONFIG, 32'h04);
    apb(1, `UBN_IDX_CTRL3, 32'h40);
    apb(1, `UBN_IDX_DATA, 32'hA5);
    repeat (3) @(posedge pclk);
    chk("tx word", 9'h1A5, last_word);
    apb(1, `UBN_IDX_DATA, 32'h5A);
    repeat (3) @(posedge pclk);
    chk("tx word kept", 9'h15A, last_word);
    apb(1, `UBN_IDX_CTRL3, 32'h10);
    repeat (2) @(posedge pclk);
    chk("tx inverted", 9'(tx_serial), 9'(tx_pin_out));
    $display("transmit done");
    ubn_peer_i.frame(9'h13C, 4'h0);
    repeat (2) @(posedge pclk);
    apb(0, `UBN_IDX_CTRL3, 0);
    chk("rx ninth", 9'h001, 9'(rd[7]));
    apb(0, `UBN_IDX_DATA, 0);
    chk("rx data", 9'h03C, rd[8:0]);
    $display("receive done");
    for (int i = 0; i < 4; i++) begin
      apb(1, `UBN_IDX_CTRL3, 32'h1 << i);
      ubn_peer_i.frame(9'h000, 4'h1 << i);
      repeat (2) @(posedge pclk);
      chk("irq raised", 9'h001, 9'(serial_irq));
      apb(1, `UBN_IDX_CTRL3, 0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 9'h000, 9'(serial_irq));
      apb(1, `UBN_IDX_STATUS, 32'h3F);
    end
    $display("interrupts done");
    apb(1, `UBN_IDX_CONFIG, 32'h02);
    apb(1, `UBN_IDX_CTRL3, 32'h02);
    ubn_peer_i.frame(9'h000, 4'h2);
    repeat (2) @(posedge pclk);
    apb(0, `UBN_IDX_STATUS, 0);
    chk("long break status", 9'h000, rd[8:0]);
    for (int m = 0; m < 3; m++) begin
      apb(1, `UBN_IDX_CONFIG, m == 0 ? 32'h0 : 32'h1 + m);
      ubn_peer_i.line(1, m != 2);
      ubn_peer_i.line(9 + (m > 0), m == 2);
      repeat (4) @(posedge pclk);
      apb(0, `UBN_IDX_STATUS, 0);
      chk("no early break", 9'h000, 9'(rd[5]));
      ubn_peer_i.line(1, m == 2);
      repeat (4) @(posedge pclk);
      apb(0, `UBN_IDX_STATUS, 0);
      chk("break seen", 9'h001, 9'(rd[5]));
      ubn_peer_i.line(1, m != 2);
      apb(1, `UBN_IDX_STATUS, 32'h3F);
    end
    chk("break pulses", 9'h003, n_breaks);
    $display("break done");
    apb(1, `UBN_IDX_CONFIG, 32'h18);
    for (int d = 0; d < 2; d++) begin
      apb(1, `UBN_IDX_CTRL3, 32'h20 * d);
      repeat (2) @(posedge pclk);
      chk("pin dir", 9'(d), 9'(tx_pin_oe));
    end
    $display("single wire done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("oe in reset", 9'h000, 9'(tx_pin_oe));
    presetn <= 1'b1;
    apb(0, `UBN_IDX_CONFIG, 0);
    chk("config after reset", 9'h000, rd[8:0]);
    chk("oe after reset", 9'h001, 9'(tx_pin_oe));
    $display("reset done");
    give_verdict();
  end
endmodule // ubn_top_bench
bind ubn_top ubn_top_chk ubn_top_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .pwdata, .rx_pin, .rx_line, .bit_tick, .rx_frame_done, .rx_framing_err, .tx_serial,
  .tx_pin_out, .tx_pin_oe, .tx_load, .nine_bit_mode, .break_detect, .serial_irq, .tx_word);
`default_nettype wire
